/* uief_top.sv */
// Interrupt enable and flag logic of the serial port
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module uief_top
  import uief_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic collision_detected_i,
  input wire logic inconsistent_sync_i,
  input wire logic buffer_overflow_i,
  input wire logic frame_error_i,
  input wire logic parity_error_i,
  input wire logic frame_format_autobaud_i,
  input wire logic break_rx_i,
  input wire logic clear_to_send_change_i,
  input wire logic start_seen_i,
  input wire logic start_of_frame_detect_enable_i,
  input wire logic unread_data_i,
  input wire logic tx_idle_i,
  input wire logic data_reg_empty_i,
  input wire logic data_written_i,
  output logic [7:0] irq_enable_o,
  output logic irq_o
);
  logic [7:0] en_q, en_d;
  logic [7:0] flg_q, flg_d;
  logic [31:0] rd_q, rd_d;
  logic rdy_q, err_q, irq_q, irq_d;
  wire logic wr_clr, wr_set, wr_flg, hit;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  uief_apb_dec u_dec (
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .wr_enclr_o(wr_clr),
    .wr_enset_o(wr_set),
    .wr_flag_o(wr_flg),
    .hit_o(hit)
  );

  wire logic setup = psel_i & ~penable_i;
  wire logic [7:0] wd = pwdata_i[7:0] & UIEF_IMPL_MASK;

  // ----------------------------------------
  // Enable register
  // ----------------------------------------
  wire logic [7:0] en_set = wr_set ? wd : 8'h00; // [R2] [R3]
  wire logic [7:0] en_clr = wr_clr ? wd : 8'h00; // [R1] [R3]
  assign en_d = (en_q | en_set) & ~en_clr; // [R4]

  // ----------------------------------------
  // Flag sources and clears
  // ----------------------------------------
  wire logic any_err = collision_detected_i | inconsistent_sync_i |
    buffer_overflow_i | frame_error_i | parity_error_i; // [R6]
  wire logic brk = frame_format_autobaud_i & break_rx_i; // [R8]
  wire logic receive_start = start_seen_i & start_of_frame_detect_enable_i; // [R14]
  wire logic [7:0] evt = {any_err, 1'b0, brk, clear_to_send_change_i,
    receive_start, 1'b0, tx_idle_i & ~data_written_i, 1'b0}; // [R5] [R12]
  wire logic [7:0] fclr = wr_flg ? (wd & UIEF_W1C_MASK) : 8'h00; // [R7] [R3]
  wire logic [7:0] sticky = ((flg_q & ~fclr) | evt) & UIEF_W1C_MASK;
  wire logic txc_kill = data_written_i;
  wire logic [7:0] txc_keep = txc_kill ? ~(8'h01 << UIEF_BIT_TXC) : 8'hff;

  always_comb begin
    flg_d = sticky & txc_keep; // [R12]
    flg_d[UIEF_BIT_RXC] = unread_data_i; // [R11]
    flg_d[UIEF_BIT_DRE] = data_reg_empty_i & ~data_written_i; // [R13]
  end

  assign irq_d = |(flg_d & en_d); // [R10]

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire logic flag_addr = (paddr_i == {UIEF_OFF_FLAG[5:0], 2'b00});
  wire logic [7:0] rsel = flag_addr ? flg_q : en_q; // [R4]
  assign rd_d = (setup & ~pwrite_i & hit) ? {24'h000000, rsel} : 32'h0;

  // ----------------------------------------
  // State
  // ----------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= UIEF_RST_EN; // [R9]
      flg_q <= UIEF_RST_FLAG; // [R9]
      irq_q <= 1'b0;
      rd_q <= 32'h0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      en_q <= en_d;
      flg_q <= flg_d;
      irq_q <= irq_d;
      rd_q <= setup ? rd_d : rd_q;
      rdy_q <= setup;
      err_q <= setup & ~hit;
    end
  end

  assign prdata_o = rd_q;
  assign pready_o = rdy_q;
  assign pslverr_o = err_q;
  assign irq_enable_o = en_q;
  assign irq_o = irq_q;
endmodule

/* uief_pkg.sv */
// Package of constants for the USART interrupt enable and flag block
// Summary of operation
// R1: Write one to clear view disables bit
// R2: Write one to set view enables bit
// R3: Writing zero leaves enables and flags unchanged
// R4: Both views read one shared enable set
// R5: Bits: error 7, break 5, cts 4..dre 0
// R6: Any receiver error status sets error flag
// R7: Write one clears error, break, cts change, receive start and transmit complete flags
// R8: Break received in auto-baud sets break flag
// R9: Enables and flags reset to zero
// R10: Interrupt high when enabled flag set
// R11: Receive complete follows unread data, no write clear
// R12: Transmit complete set when idle, cleared by write/data
// R13: Data empty follows empty data register
// R14: Start seen with detection enabled sets receive start
package uief_pkg;
  localparam logic [7:0] UIEF_OFF_ENCLR = 8'h14;
  localparam logic [7:0] UIEF_OFF_ENSET = 8'h16;
  localparam logic [7:0] UIEF_OFF_FLAG = 8'h18;
  localparam int UIEF_BIT_ERROR = 7;
  localparam int UIEF_BIT_BREAK = 5;
  localparam int UIEF_BIT_CTSC = 4;
  localparam int UIEF_BIT_RXS = 3;
  localparam int UIEF_BIT_RXC = 2;
  localparam int UIEF_BIT_TXC = 1;
  localparam int UIEF_BIT_DRE = 0;
  localparam logic [7:0] UIEF_IMPL_MASK = 8'hbf;
  localparam logic [7:0] UIEF_W1C_MASK = 8'hba;
  localparam logic [7:0] UIEF_RST_EN = 8'h00;
  localparam logic [7:0] UIEF_RST_FLAG = 8'h00;
endpackage

/* uief_apb_dec.sv */
// APB decoder for the interrupt registers
`timescale 1ns/100ps
module uief_apb_dec
  import uief_pkg::*;
(
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  output logic wr_enclr_o,
  output logic wr_enset_o,
  output logic wr_flag_o,
  output logic hit_o
);
  wire logic acc = psel_i & penable_i;
  // Offsets are word indices; the byte address is four times the index
  wire logic is_clr = (paddr_i == {UIEF_OFF_ENCLR[5:0], 2'b00});
  wire logic is_set = (paddr_i == {UIEF_OFF_ENSET[5:0], 2'b00});
  wire logic is_flg = (paddr_i == {UIEF_OFF_FLAG[5:0], 2'b00});
  assign hit_o = is_clr | is_set | is_flg;
  assign wr_enclr_o = acc & pwrite_i & is_clr;
  assign wr_enset_o = acc & pwrite_i & is_set;
  assign wr_flag_o = acc & pwrite_i & is_flg;
endmodule

/* uief_asserts.sv */
// Port assertions for the interrupt enable and flag block
`timescale 1ns/100ps
module uief_asserts (
  input wire logic mclk_i, rst_i, psel_i, penable_i, pwrite_i,
  input wire logic collision_detected_i, irq_o,
  input wire logic [7:0] paddr_i, irq_enable_o,
  input wire logic [31:0] pwdata_i
);
  wire ws = psel_i & penable_i & pwrite_i & paddr_i == 8'h58;
  wire wc = psel_i & penable_i & pwrite_i & paddr_i == 8'h50;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_set; ws && pwdata_i[5] |=> irq_enable_o[5]; endproperty
  a_set: assert property (p_set) else $error("set lost");
  property p_clr; wc && pwdata_i[5] |=> !irq_enable_o[5]; endproperty
  a_clr: assert property (p_clr) else $error("clear lost");
  property p_keep; !ws && !wc |=> $stable(irq_enable_o); endproperty
  a_keep: assert property (p_keep) else $error("enable moved");
  property p_err;
    collision_detected_i && irq_enable_o[7] && !(wc && pwdata_i[7]) |=> irq_o;
  endproperty
  a_err: assert property (p_err) else $error("no error irq");
  property p_off; (irq_enable_o == 8'h00)[*2] |-> !irq_o; endproperty
  a_off: assert property (p_off) else $error("masked irq");
  property p_on; irq_o |-> |irq_enable_o || |$past(irq_enable_o); endproperty
  a_on: assert property (p_on) else $error("irq unenabled");
  property p_rst; $fell(rst_i) |-> irq_enable_o == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_b6; irq_enable_o[6] == 1'b0; endproperty
  a_b6: assert property (p_b6) else $error("bit 6 set");
endmodule
bind uief_top uief_asserts u_chk (.*);

/* uief_node.sv */
// Remote serial node model driving line events
`timescale 1ns/100ps
module uief_node (input wire logic mclk_i, output logic [13:0] ev_o = 14'h0);
  task automatic send(logic [13:0] v);
    @(posedge mclk_i) ev_o <= v;
    @(posedge mclk_i) ev_o <= 14'h0;
  endtask
  // Drive a level that stays until the next call
  task automatic hold(logic [13:0] v);
    @(posedge mclk_i) ev_o <= v;
  endtask
endmodule

/* uief_tb.sv */
// Bench for the interrupt enable and flag block
`timescale 1ns/100ps
module testbench;
  logic mclk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic pready_o, pslverr_o, irq_o;
  logic [7:0] paddr_i = 0, irq_enable_o;
  logic [31:0] pwdata_i = 0, prdata_o;
  logic [13:0] ev;
  int mismatches = 0, comparisons = 0;
  logic slverr_seen = 0;
  always #50 mclk_i = ~mclk_i;
  uief_node node (.mclk_i(mclk_i), .ev_o(ev));
  uief_top uut (.*, .collision_detected_i(ev[0]),
    .inconsistent_sync_i(ev[1]), .buffer_overflow_i(ev[2]),
    .frame_error_i(ev[3]), .parity_error_i(ev[4]), .break_rx_i(ev[6]),
    .frame_format_autobaud_i(ev[5]), .clear_to_send_change_i(ev[7]),
    .start_seen_i(ev[8]), .start_of_frame_detect_enable_i(ev[9]),
    .unread_data_i(ev[10]), .tx_idle_i(ev[11]), .data_reg_empty_i(ev[12]),
    .data_written_i(ev[13]));
  task automatic chk(string s, logic [32:0] e, g);
    comparisons++;
    if (g !== e) $display("wrong value %s %h %h", s, e, g);
    mismatches += g !== e;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    @(posedge mclk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    for (int i = 0; i < 9 && pready_o !== 1'b1; i++) @(posedge mclk_i);
    if (pready_o !== 1'b1) mismatches++;
    slverr_seen = pslverr_o;
    if (!w) chk("irq and data", e, {irq_o, prdata_o});
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic tally_and_finish;
    $display("%0d checks %0d wrong", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000 mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    apb(0, 8'h60, 0, 0);
    apb(1, 8'h58, 32'hff, 0);
    apb(1, 8'h50, 32'h21, 0);
    apb(0, 8'h58, 0, 33'h9e);
    chk("enables", 33'h9e, {1'b0, 24'h0, irq_enable_o});
    apb(0, 8'h50, 0, 33'h9e);
    apb(0, 8'h70, 0, 0);
    chk("slave error", 33'h1, {32'h0, slverr_seen});
    for (int i = 0; i < 8; i++) begin
      node.send(i < 7 ? 14'h1 << i : 14'h60);
      apb(1, 8'h60, 32'h5f, 0);
      apb(0, 8'h60, 0, i < 5 ? 33'h100000080 : i > 6 ? 33'h20 : 0);
      apb(1, 8'h60, 32'ha0, 0);
    end
    node.hold(14'h1f80);
    node.hold(14'h1400);
    apb(0, 8'h60, 0, 33'h10000001f);
    apb(1, 8'h60, 32'hff, 0);
    apb(0, 8'h60, 0, 33'h100000005);
    node.hold(14'h0800);
    node.hold(14'h2000);
    node.hold(14'h0000);
    apb(0, 8'h60, 0, 0);
    $display("register tests done");
    tally_and_finish;
  end
endmodule
